// ### rtl/hsc_pkg.sv
// Purpose: shared constants, types and input-allocation table for the counter bank
// Assumes: eight input terminals, 21 counter channels in three families
// Notes:   the allocation table is a function so the alternate relay can steer it
package hsc_pkg;

    localparam int          HSC_W       = 32;           // counter width
    localparam int          HSC_NIN     = 8;            // input terminals
    localparam int          HSC_NCH     = 21;           // channels in the bank
    localparam int          HSC_NSGL    = 11;           // single-input channels
    localparam int          HSC_NDUAL   = 5;            // two-input channels
    localparam int          HSC_NQUAD   = 5;            // quadrature channels
    localparam int          HSC_DUAL_LO = 11;           // first two-input channel
    localparam int          HSC_QUAD_LO = 16;           // first quadrature channel
    localparam logic [3:0]  HSC_NONE    = 4'hF;         // no terminal assigned
    localparam logic [31:0] HSC_MAX     = 32'h7FFFFFFF; // largest positive value
    localparam logic [31:0] HSC_MIN     = 32'h80000000; // most negative value
    localparam logic [31:0] HSC_ZERO    = 32'h00000000; // value after any clear
    localparam logic        HSC_DIR_UP  = 1'b0;         // direction flag: counting up
    localparam logic        HSC_DIR_DN  = 1'b1;         // direction flag: counting down

    // channel family
    typedef enum logic [1:0] {
        HSC_SINGLE,
        HSC_DUAL,
        HSC_QUAD
    } hsc_kind_e;

    // terminal allocation of one channel
    typedef struct packed {
        hsc_kind_e  kind;   // family
        logic [3:0] a;      // count / up / phase A terminal
        logic [3:0] b;      // down / phase B terminal
        logic [3:0] r;      // external reset terminal
        logic [3:0] s;      // external start terminal
    } hsc_cfg_s;

    // allocation table; alt selects the switched assignment of three channels
    function automatic hsc_cfg_s hsc_cfg(input int ch, input logic alt);
        hsc_cfg_s c;
        c = '{HSC_SINGLE, HSC_NONE, HSC_NONE, HSC_NONE, HSC_NONE};
        case (ch)
            0:  c = '{HSC_SINGLE, 4'h0, HSC_NONE, HSC_NONE, HSC_NONE};
            1:  c = '{HSC_SINGLE, 4'h1, HSC_NONE, HSC_NONE, HSC_NONE};
            2:  c = '{HSC_SINGLE, 4'h2, HSC_NONE, HSC_NONE, HSC_NONE};
            3:  c = '{HSC_SINGLE, 4'h3, HSC_NONE, HSC_NONE, HSC_NONE};
            4:  c = '{HSC_SINGLE, 4'h4, HSC_NONE, HSC_NONE, HSC_NONE};
            5:  c = '{HSC_SINGLE, 4'h5, HSC_NONE, HSC_NONE, HSC_NONE};
            6:  c = '{HSC_SINGLE, 4'h0, HSC_NONE, 4'h1, HSC_NONE};
            7:  c = '{HSC_SINGLE, 4'h2, HSC_NONE, 4'h3, HSC_NONE};
            8:  c = '{HSC_SINGLE, 4'h4, HSC_NONE, 4'h5, HSC_NONE};
            9:  c = '{HSC_SINGLE, 4'h0, HSC_NONE, 4'h1, 4'h6};
            10: c = '{HSC_SINGLE, 4'h2, HSC_NONE, 4'h3, 4'h7};
            11: c = '{HSC_DUAL, 4'h0, 4'h1, HSC_NONE, HSC_NONE};
            12: c = '{HSC_DUAL, 4'h0, 4'h1, 4'h2, HSC_NONE};
            13: c = alt ? '{HSC_DUAL, 4'h3, 4'h4, HSC_NONE, HSC_NONE}
                        : '{HSC_DUAL, 4'h3, 4'h4, 4'h5, HSC_NONE};
            14: c = '{HSC_DUAL, 4'h0, 4'h1, 4'h2, 4'h6};
            15: c = '{HSC_DUAL, 4'h3, 4'h4, 4'h5, 4'h7};
            16: c = '{HSC_QUAD, 4'h0, 4'h1, HSC_NONE, HSC_NONE};
            17: c = '{HSC_QUAD, 4'h0, 4'h1, 4'h2, HSC_NONE};
            18: c = alt ? '{HSC_QUAD, 4'h3, 4'h4, HSC_NONE, HSC_NONE}
                        : '{HSC_QUAD, 4'h3, 4'h4, 4'h5, HSC_NONE};
            19: c = alt ? '{HSC_QUAD, 4'h6, 4'h7, HSC_NONE, HSC_NONE}
                        : '{HSC_QUAD, 4'h0, 4'h1, 4'h2, 4'h6};
            20: c = '{HSC_QUAD, 4'h3, 4'h4, 4'h5, 4'h7};
            default: c = '{HSC_SINGLE, HSC_NONE, HSC_NONE, HSC_NONE, HSC_NONE};
        endcase
        return c;
    endfunction

    // pick one terminal of a vector; an unassigned slot reads as low
    function automatic logic hsc_pick(input logic [7:0] v, input logic [3:0] idx);
        return (idx == HSC_NONE) ? 1'b0 : v[idx[2:0]];
    endfunction

endpackage

// ### rtl/hsc_chan.sv
// Purpose: one 32-bit ring counter with compare output and direction flag
// Assumes: up/down events are one-cycle pulses already gated by run state
// Notes:   value and compare carry no plain reset; cold start and program reset clear both, external reset the value
`timescale 1ns/1ps
`default_nettype none
module hsc_chan
    import hsc_pkg::*;
#(
    parameter int W = HSC_W
) (
    input  wire logic         clk,       // system clock
    input  wire logic         cold_clr,  // sync clear of retained state
    input  wire logic         rst,       // sync reset of volatile state
    input  wire logic         up_evt,    // increment pulse
    input  wire logic         dn_evt,    // decrement pulse
    input  wire logic         ext_clr,   // external reset level
    input  wire logic         prog_rst,  // program reset command
    input  wire logic [W-1:0] setpoint,  // compare setpoint
    output logic      [W-1:0] value,     // current value
    output logic              cmp,       // compare output
    output logic              dir        // 1 while counting down
);

    wire logic         step_up  = up_evt & ~dn_evt;       // net increment
    wire logic         step_dn  = dn_evt & ~up_evt;       // net decrement
    wire logic [W-1:0] sp_m1    = setpoint - W'(1);       // one below setpoint
    wire logic [W-1:0] next_inc = value + W'(1);          // wraps max to min
    wire logic [W-1:0] next_dec = value - W'(1);          // wraps min to max

    // retained counter and compare; clears outrank counting
    always_ff @(posedge clk) begin
        if (cold_clr) begin
            value <= HSC_ZERO;
            cmp   <= 1'b0;
        end else if (prog_rst) begin
            value <= HSC_ZERO;
            cmp   <= 1'b0;
        end else if (ext_clr) begin
            value <= HSC_ZERO;
        end else if (step_up) begin
            value <= next_inc;
            if (value == sp_m1) begin
                cmp <= 1'b1;
            end
        end else if (step_dn) begin
            value <= next_dec;
            if (value == setpoint) begin
                cmp <= 1'b0;
            end
        end
    end

    // direction flag follows the last counted step
    always_ff @(posedge clk) begin
        if (rst) begin
            dir <= HSC_DIR_UP;
        end else if (step_dn) begin
            dir <= HSC_DIR_DN;
        end else if (step_up) begin
            dir <= HSC_DIR_UP;
        end
    end

    wire logic quiet = ~cold_clr & ~prog_rst & ~ext_clr; // no clear pending

    sequence s_up_at(logic [W-1:0] v);
        quiet && step_up && value == v;
    endsequence

    sequence s_dn_at(logic [W-1:0] v);
        quiet && step_dn && value == v;
    endsequence

    property p_wrap_up;
        @(posedge clk) disable iff (rst) s_up_at(HSC_MAX) |=> value == HSC_MIN;
    endproperty
    a_wrap_up: assert property (p_wrap_up) else $error("no wrap to min");

    property p_wrap_dn;
        @(posedge clk) disable iff (rst) s_dn_at(HSC_MIN) |=> value == HSC_MAX;
    endproperty
    a_wrap_dn: assert property (p_wrap_dn) else $error("no wrap to max");

    property p_cmp_set;
        @(posedge clk) disable iff (rst) s_up_at(sp_m1) |=> cmp && value == $past(setpoint);
    endproperty
    a_cmp_set: assert property (p_cmp_set) else $error("compare not set");

    property p_cmp_clr;
        @(posedge clk) disable iff (rst) s_dn_at(setpoint) |=> !cmp;
    endproperty
    a_cmp_clr: assert property (p_cmp_clr) else $error("compare not cleared");

    property p_prog_rst;
        @(posedge clk) disable iff (rst) prog_rst |=> value == HSC_ZERO && !cmp;
    endproperty
    a_prog_rst: assert property (p_prog_rst) else $error("program reset failed");

    property p_ext_clr;
        @(posedge clk) disable iff (rst) (ext_clr && !cold_clr) |=> value == HSC_ZERO;
    endproperty
    a_ext_clr: assert property (p_ext_clr) else $error("external reset failed");

    property p_step;
        @(posedge clk) disable iff (rst)
            (quiet && step_up) |=> value == $past(value) + W'(1) && !dir;
    endproperty
    a_step: assert property (p_step) else $error("step up wrong");

endmodule // hsc_chan
`default_nettype wire

// ### rtl/hsc_bank.sv
// Purpose: bank of 21 high-speed up/down counters fed from eight terminals
// Assumes: terminals synchronous-safe after two flops; one clock CLK_SYS
// Notes:   per-channel vectors are flat, channel n in slice n
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - each channel holds 32-bit signed value
// - counter wraps at both signed ends
// - single-input counts rising edges while enabled
// - single-input direction bit: set down, clear up
// - two-input: up input increments, down decrements
// - two-input direction flag readable, set down
// - quadrature picks direction from phase relation
// - quadrature direction flag readable, set down
// - start input begins counting while enabled
// - external reset clears value at once
// - program reset zeroes value, clears compare
// - compare sets at setpoint, clears below it
// - counting independent of compare output state
// - value, compare, reset state survive power loss
// - value updates on each counted event
// - full single: count 0, reset 1, start 6
// - full two-input: 0 up, 1 down, 2, 6
// - full quadrature: A 0, B 1, 2, 6
// - alternate relay remaps three channels, no reset/start
module hsc_bank
    import hsc_pkg::*;
#(
    parameter int W   = HSC_W,
    parameter int NCH = HSC_NCH
) (
    input  wire logic                 CLK_SYS,      // 125 MHz system clock
    input  wire logic                 SYS_RST,      // sync reset, active high
    input  wire logic                 COLD_START,   // with SYS_RST: clear retained state
    input  wire logic [HSC_NIN-1:0]   HS_IN,        // input_0 .. input_7
    input  wire logic                 ALT_ASSIGN,   // alternate-assignment relay
    input  wire logic [NCH-1:0]       COUNT_EN,     // count_enable_condition
    input  wire logic [NCH-1:0]       PROG_RST,     // program reset command pulses
    input  wire logic [HSC_NSGL-1:0]  DIR_CTRL,     // single_input_direction_ctrl
    input  wire logic [NCH*W-1:0]     SETPOINT,     // compare setpoints
    output logic      [NCH*W-1:0]     VALUE,        // current values
    output logic      [NCH-1:0]       CMP_OUT,      // compare outputs
    output logic      [HSC_NDUAL-1:0] DUAL_DIR,     // dual_input_direction_flag
    output logic      [HSC_NQUAD-1:0] QUAD_DIR      // quadrature_direction_flag
);

    // terminal synchroniser; stage one feeds stage two and nothing else
    logic [HSC_NIN-1:0] sync1;      // first stage
    logic [HSC_NIN-1:0] sync2;      // stable level
    logic [HSC_NIN-1:0] sync3;      // previous level for edge detect

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= HS_IN;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // rising edges seen on the synchronised levels
    wire logic [HSC_NIN-1:0] rise = sync2 & ~sync3;

    // retained state clears only on a cold start, so a warm reset keeps it
    wire logic cold_clr = SYS_RST & COLD_START;

    logic [NCH-1:0] dir_all;  // direction flag of every channel
    logic [NCH-1:0] run_all;  // counting allowed, per channel

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_ch
            // terminal allocation, live so the relay can switch it
            hsc_cfg_s cfg;
            assign cfg = hsc_cfg(ch, ALT_ASSIGN);

            wire logic a_rise  = hsc_pick(rise,  cfg.a);   // count / up / phase A edge
            wire logic b_rise  = hsc_pick(rise,  cfg.b);   // down edge
            wire logic b_lvl   = hsc_pick(sync2, cfg.b);   // phase B level
            wire logic r_lvl   = hsc_pick(sync2, cfg.r);   // external reset level
            wire logic s_rise  = hsc_pick(rise,  cfg.s);   // external start edge
            wire logic has_st  = (cfg.s != HSC_NONE);      // channel has a start input
            wire logic en      = COUNT_EN[ch];
            wire logic dctl;                               // single-input direction

            if (ch < HSC_NSGL) begin : g_dctl
                assign dctl = DIR_CTRL[ch];
            end else begin : g_nodctl
                assign dctl = 1'b0;
            end

            // start latch: armed by the start edge, dropped with the enable
            logic started;
            always_ff @(posedge CLK_SYS) begin
                if (SYS_RST) begin
                    started <= 1'b0;
                end else if (!en || PROG_RST[ch]) begin
                    started <= 1'b0;
                end else if (s_rise) begin
                    started <= 1'b1;
                end
            end

            wire logic run = has_st ? (en & started) : en;
            assign run_all[ch] = run;

            // event decode per family
            wire logic up_sgl  = a_rise & ~dctl;
            wire logic dn_sgl  = a_rise & dctl;
            wire logic up_quad = a_rise & ~b_lvl;
            wire logic dn_quad = a_rise & b_lvl;
            wire logic up_evt  = run & ((cfg.kind == HSC_SINGLE) ? up_sgl :
                                        (cfg.kind == HSC_DUAL)   ? a_rise : up_quad);
            wire logic dn_evt  = run & ((cfg.kind == HSC_SINGLE) ? dn_sgl :
                                        (cfg.kind == HSC_DUAL)   ? b_rise : dn_quad);

            hsc_chan #(
                .W        (W)
            ) u_chan (
                .clk      (CLK_SYS),
                .cold_clr (cold_clr),
                .rst      (SYS_RST),
                .up_evt   (up_evt),
                .dn_evt   (dn_evt),
                .ext_clr  (r_lvl),
                .prog_rst (PROG_RST[ch]),
                .setpoint (SETPOINT[ch*W +: W]),
                .value    (VALUE[ch*W +: W]),
                .cmp      (CMP_OUT[ch]),
                .dir      (dir_all[ch])
            );
        end
    endgenerate

    // flags of the two families that report direction
    assign DUAL_DIR = dir_all[HSC_DUAL_LO +: HSC_NDUAL];
    assign QUAD_DIR = dir_all[HSC_QUAD_LO +: HSC_NQUAD];

    // helpers for the checks below; channel 0, 9, 14 and 16 are watched
    wire logic [W-1:0] val0  = VALUE[0 +: W];
    wire logic [W-1:0] val9  = VALUE[9*W +: W];
    wire logic [W-1:0] val16 = VALUE[16*W +: W];

    sequence s_in_stable;
        !SYS_RST && !$past(SYS_RST) && !$past(SYS_RST, 2);
    endsequence

    property p_sync;
        @(posedge CLK_SYS) s_in_stable |-> sync2 == $past(HS_IN, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("synchroniser depth wrong");

    property p_sgl_up;
        @(posedge CLK_SYS) disable iff (SYS_RST)
            (rise[0] && COUNT_EN[0] && !DIR_CTRL[0] && !PROG_RST[0])
            |=> val0 == $past(val0) + W'(1);
    endproperty
    a_sgl_up: assert property (p_sgl_up) else $error("single channel missed edge");

    property p_sgl_idle;
        @(posedge CLK_SYS) disable iff (SYS_RST)
            (!COUNT_EN[0] && !PROG_RST[0]) |=> val0 == $past(val0);
    endproperty
    a_sgl_idle: assert property (p_sgl_idle) else $error("counted while disabled");

    property p_full_rst;
        @(posedge CLK_SYS) disable iff (SYS_RST) sync2[1] |=> val9 == HSC_ZERO;
    endproperty
    a_full_rst: assert property (p_full_rst) else $error("input_1 reset ignored");

    property p_start_gate;
        @(posedge CLK_SYS) disable iff (SYS_RST)
            (!run_all[14] && !sync2[2] && !PROG_RST[14]) |=> VALUE[14*W +: W] == $past(VALUE[14*W +: W]);
    endproperty
    a_start_gate: assert property (p_start_gate) else $error("counted before start");

    property p_quad_dir;
        @(posedge CLK_SYS) disable iff (SYS_RST)
            (!ALT_ASSIGN && rise[0] && sync2[1] && COUNT_EN[16] && !PROG_RST[16])
            |=> QUAD_DIR[0] && val16 == $past(val16) - W'(1);
    endproperty
    a_quad_dir: assert property (p_quad_dir) else $error("phase B lead not down");

endmodule // hsc_bank
`default_nettype wire

// ### testbench/hsc_src.sv
// Purpose: pulse source and two-phase encoder driving the eight terminals
// Assumes: terminals idle low (open collector off), driven at the falling edge
// Notes:   every level is held two cycles so the two-flop synchroniser sees it
`timescale 1ns/1ps
`default_nettype none
module hsc_src (
    input  wire logic       clk,   // system clock
    output logic      [7:0] hs_in  // terminal levels input_0 .. input_7
);
    // released terminals read low, the input's own idle level
    initial hs_in = 8'h00;

    // wait n falling edges
    task automatic hold(input int n);
        repeat (n) @(negedge clk);
    endtask

    // one rising edge on terminal t; the low tail lets the count land
    task automatic pulse(input int t);
        @(negedge clk) hs_in[t] = 1'b1;
        hold(2);
        hs_in[t] = 1'b0;
        hold(4);
    endtask

    // one encoder cycle, phases a quarter apart; dn lets phase b lead
    task automatic quad(input int a, input int b, input logic dn);
        int f;
        int s;
        f = dn ? b : a;
        s = dn ? a : b;
        @(negedge clk) hs_in[f] = 1'b1;
        hold(2);
        hs_in[s] = 1'b1;
        hold(2);
        hs_in[f] = 1'b0;
        hold(2);
        hs_in[s] = 1'b0;
        hold(4);
    endtask
endmodule // hsc_src
`default_nettype wire

// ### testbench/hsc_bank_test.sv
// Purpose: self-checking bench for the counter bank
// Assumes: one channel enabled at a time, so one terminal has one user
// Notes:   wrap at the signed ends needs 2^31 events and is not reached here
`timescale 1ns/1ps
`default_nettype none
module hsc_bank_test
    import hsc_pkg::*;
;
    // reset terminal per channel, 8 = none; count terminal of channels 0..8
    localparam int RT [HSC_NCH] = '{8,8,8,8,8,8,1,3,5,1,3,8,2,5,2,5,8,2,5,2,5};
    localparam int CT [9]       = '{0,1,2,3,4,5,0,2,4};
    logic                     clk, rst, cold, alt;     // clock, reset, cold start, relay
    logic [7:0]               hs_in;                   // terminals from the source model
    logic [HSC_NCH-1:0]       en, prst, cmp, ecmp;     // enables, resets, compare seen/expected
    logic [HSC_NSGL-1:0]      dctl;                    // single-input direction bits
    logic [HSC_NCH*HSC_W-1:0] sp, val;                 // setpoints, values
    logic [HSC_NDUAL-1:0]     ddir, edd;               // two-input direction seen/expected
    logic [HSC_NQUAD-1:0]     qdir, eqd;               // quadrature direction seen/expected
    logic [31:0]              ev [HSC_NCH];            // expected values
    logic [31:0]              seed = 32'h0A54;         // xorshift state
    logic [31:0]              r;                       // current random word
    int                       failures, n_checks, cyc; // counters

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    hsc_bank #(.W(HSC_W), .NCH(HSC_NCH)) hsc_bank_i (
        .CLK_SYS(clk), .SYS_RST(rst), .COLD_START(cold), .HS_IN(hs_in), .ALT_ASSIGN(alt),
        .COUNT_EN(en), .PROG_RST(prst), .DIR_CTRL(dctl), .SETPOINT(sp), .VALUE(val),
        .CMP_OUT(cmp), .DUAL_DIR(ddir), .QUAD_DIR(qdir));
    hsc_src hsc_src_i (.clk(clk), .hs_in(hs_in));

    // repeatable random words
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // one step of a 32-bit ring counter
    function automatic logic [31:0] nxt(input logic [31:0] v, input logic dn);
        return dn ? v - 32'h1 : v + 32'h1;
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, want, seen);
        end
    endtask

    // compare every output against the model
    task automatic chk_all();
        for (int i = 0; i < HSC_NCH; i++) begin
            chk("value", val[i*HSC_W +: HSC_W], ev[i]);
        end
        chk("compare", {11'h0, cmp}, {11'h0, ecmp});
        chk("dual_dir", {27'h0, ddir}, {27'h0, edd});
        chk("quad_dir", {27'h0, qdir}, {27'h0, eqd});
    endtask

    // a high level on t zeroes every channel using t as external reset
    task automatic clear_ext(input int t);
        for (int i = 0; i < HSC_NCH; i++) begin
            if (RT[i] == t && !(alt && (i == 13 || i == 18 || i == 19))) begin
                ev[i] = 32'h0;
            end
        end
    endtask

    task automatic tick(input int t);
        hsc_src_i.pulse(t);
        clear_ext(t);
    endtask

    task automatic qtick(input int a, input int b, input logic dn);
        hsc_src_i.quad(a, b, dn);
        clear_ext(a);
        clear_ext(b);
    endtask

    // enable exactly one channel, so no terminal serves two counters
    task automatic sel(input int ch);
        @(negedge clk);
        en = {{(HSC_NCH-1){1'b0}}, 1'b1} << ch;
    endtask

    task automatic do_reset(input logic c);
        @(negedge clk);
        rst = 1'b1;
        cold = c;
        repeat (8) @(negedge clk);
        rst = 1'b0;
    endtask

    task automatic give_verdict();
        if (failures == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // a hang costs one mismatch and ends the run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            give_verdict();
        end
    end

    initial begin
        rst = 1'b1; cold = 1'b1; alt = 1'b0; en = '0; prst = '0; dctl = '0;
        for (int i = 0; i < HSC_NCH; i++) begin
            r = rnd();
            sp[i*HSC_W +: HSC_W] = {2'b01, r[29:0]}; // far from any reachable value
            ev[i] = 32'h0;
        end
        sp[0 +: HSC_W] = 32'hFFFFFFFB; // channel 0 compares at -5
        ecmp = '0; edd = '0; eqd = '0;
        do_reset(1'b1);
        chk_all();
        // single-input channels, random direction and count
        for (int c = 0; c < 9; c++) begin
            r = rnd();
            sel(c);
            dctl = r[HSC_NSGL-1:0];
            for (int k = 0; k <= int'(r[20:19]); k++) begin
                tick(CT[c]);
                ev[c] = nxt(ev[c], r[c]);
            end
            chk_all();
        end
        // no counting while disabled; reset terminals still clear
        @(negedge clk) en = '0;
        tick(0);
        tick(1);
        tick(3);
        tick(5);
        chk_all();
        // compare output of channel 0 around -5
        sel(0);
        dctl = 11'h001;
        while (ev[0] !== 32'hFFFFFFFA) begin
            tick(0);
            ev[0] = nxt(ev[0], 1'b1);
        end
        chk_all();
        dctl = 11'h000;
        tick(0);
        ev[0] = 32'hFFFFFFFB;
        ecmp[0] = 1'b1;
        chk_all();
        tick(0);
        tick(0);
        ev[0] = 32'hFFFFFFFD;
        chk_all();
        dctl = 11'h001;
        tick(0);
        tick(0);
        ev[0] = 32'hFFFFFFFB;
        chk_all();
        tick(0);
        ev[0] = 32'hFFFFFFFA;
        ecmp[0] = 1'b0;
        chk_all();
        dctl = 11'h000;
        tick(0);
        ev[0] = 32'hFFFFFFFB;
        ecmp[0] = 1'b1;
        @(negedge clk) prst[0] = 1'b1;
        @(negedge clk) prst[0] = 1'b0;
        @(negedge clk);
        ev[0] = 32'h0;
        ecmp[0] = 1'b0;
        chk_all();
        // two-input channel 11 and quadrature channel 16, checked each step
        sel(11);
        for (int k = 0; k < 8; k++) begin
            r = rnd();
            tick(r[0] ? 1 : 0);
            ev[11] = nxt(ev[11], r[0]);
            edd[0] = r[0];
            chk_all();
        end
        sel(16);
        for (int k = 0; k < 8; k++) begin
            r = rnd();
            qtick(0, 1, r[0]);
            ev[16] = nxt(ev[16], r[0]);
            eqd[0] = r[0];
            chk_all();
        end
        // start-armed channels ignore counts until their start edge
        sel(9);
        tick(0);
        tick(6);
        tick(0);
        ev[9] = nxt(ev[9], 1'b0);
        chk_all();
        sel(14);
        tick(0);
        tick(6);
        tick(1);
        ev[14] = nxt(ev[14], 1'b1);
        edd[3] = 1'b1;
        chk_all();
        sel(19);
        qtick(0, 1, 1'b0);
        tick(6);
        qtick(0, 1, 1'b1);
        ev[19] = nxt(ev[19], 1'b1);
        eqd[3] = 1'b1;
        chk_all();
        tick(2);
        chk_all();
        // alternate relay: new terminals, reset terminals ignored
        @(negedge clk) alt = 1'b1;
        sel(13);
        tick(3);
        ev[13] = nxt(ev[13], 1'b0);
        edd[2] = 1'b0;
        tick(5);
        chk_all();
        sel(19);
        qtick(6, 7, 1'b0);
        ev[19] = nxt(ev[19], 1'b0);
        eqd[3] = 1'b0;
        tick(2);
        chk_all();
        @(negedge clk) alt = 1'b0;
        // warm reset keeps values and compare, drops direction flags
        en = '0;
        do_reset(1'b0);
        edd = '0;
        eqd = '0;
        chk_all();
        give_verdict();
    end
endmodule // hsc_bank_test
`default_nettype wire
